// ===== design/bdaef_filter.sv
// bus data activity event filter with four counters behind APB
// assumes bus indications are asynchronous pins; master keeps APB rules
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module bdaef_filter #(
    parameter int CW = 32
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        ce,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [bdaef_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output var  logic                        pready,
    output var  logic [31:0]                 prdata,
    output var  logic                        pslverr,
    input  wire logic                        data_ready_strobe,
    input  wire logic                        data_bus_reserved,
    input  wire logic                        data_self_driven,
    input  wire logic                        data_self_sampled
);
    import bdaef_pkg::*;

    // *****************************************
    // state
    // *****************************************
    typedef struct packed {
        logic [PIN_N-1:0]         sync1;
        logic [PIN_N-1:0]         sync2;
        logic [31:0]              sel_a;
        logic [31:0]              sel_b;
        logic [CFG_W-1:0]         cfg;
        logic [NCNT-1:0][CW-1:0]  cnt;
        logic [1:0]               prev_hit;
        logic                     pready;
        logic [31:0]              prdata;
        logic                     pslverr;
    } bdaef_state_type;

    bdaef_state_type st;
    bdaef_state_type next_st;

    // *****************************************
    // functions
    // *****************************************
    function automatic logic [CAT_N-1:0] categories(
        input logic [PIN_N-1:0] p
    );
        logic [CAT_N-1:0] c;
        c = '0;
        c[CAT_RDY_DRV] = p[PIN_RDY] & p[PIN_DRV];
        c[CAT_RDY_OWN] = p[PIN_RDY] & p[PIN_SMP];
        c[CAT_RDY_OTH] = p[PIN_RDY] & ~p[PIN_SMP];
        c[CAT_BSY_DRV] = p[PIN_BSY] & p[PIN_DRV];
        c[CAT_BSY_OWN] = p[PIN_BSY] & p[PIN_SMP];
        c[CAT_BSY_OTH] = p[PIN_BSY] & ~p[PIN_SMP];
        return c;
    endfunction

    function automatic logic select_hit(
        input logic [31:0]      sel,
        input logic [CAT_N-1:0] c
    );
        logic code_ok;
        code_ok = (sel[EVSEL_MSB:EVSEL_LSB] == EVSEL_CODE);
        return code_ok && (|(sel[MASK_LSB +: CAT_N] & c));
    endfunction

    function automatic logic [2:0] reg_index(
        input logic [ADDR_W-1:0] a
    );
        logic [2:0] r;
        r = REG_NONE;
        if (a == SEL_A_OFS) begin
            r = REG_SEL_A;
        end else if (a == SEL_B_OFS) begin
            r = REG_SEL_B;
        end else if (a == CFG_OFS) begin
            r = REG_CFG;
        end
        for (int i = 0; i < NCNT; i++) begin
            if (a == CNT0_OFS + CNT_STRIDE * 8'(i)) begin
                r = REG_CNT0 + 3'(i);
            end
        end
        return r;
    endfunction

    // *****************************************
    // decode and selection
    // *****************************************
    logic [CAT_N-1:0] cats;
    logic             hit_a;
    logic             hit_b;
    logic [2:0]       idx;
    logic             acc;
    logic             wr;
    logic [31:0]      rdata;

    assign cats  = categories(st.sync2);
    assign hit_a = select_hit(st.sel_a, cats);
    assign hit_b = select_hit(st.sel_b, cats);
    assign idx   = reg_index(paddr);
    assign acc   = psel & penable;
    assign wr    = acc & st.pready & pwrite;

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (idx)
            REG_SEL_A: rdata = st.sel_a;
            REG_SEL_B: rdata = st.sel_b;
            REG_CFG:   rdata = 32'(st.cfg);
            REG_NONE:  rdata = 32'h0000_0000;
            default:   rdata = 32'(st.cnt[idx - REG_CNT0]);
        endcase
    end

    // *****************************************
    // next state
    // *****************************************
    always_comb begin
        logic h;
        logic prev;
        logic inc;
        h       = 1'b0;
        prev    = 1'b0;
        inc     = 1'b0;
        next_st = st;
        next_st.sync1 = {data_self_sampled, data_self_driven,
                         data_bus_reserved, data_ready_strobe};
        next_st.sync2 = st.sync1;
        next_st.prev_hit = {hit_b, hit_a};
        // counters 0,1 follow register a, 2,3 follow b
        for (int i = 0; i < NCNT; i++) begin
            h    = (i < NCNT_A) ? hit_a : hit_b;
            prev = (i < NCNT_A) ? st.prev_hit[0] : st.prev_hit[1];
            inc  = st.cfg[i*CFG_STRIDE+CFG_EN] &
                   (st.cfg[i*CFG_STRIDE+CFG_EDGE] ? (h & ~prev) : h);
            if (wr && idx == REG_CNT0 + 3'(i)) begin
                next_st.cnt[i] = CW'(pwdata);
            end else if (inc) begin
                next_st.cnt[i] = st.cnt[i] + CW'(1);
            end
        end
        if (wr && idx == REG_SEL_A) begin
            next_st.sel_a = pwdata & SEL_WMASK;
        end
        if (wr && idx == REG_SEL_B) begin
            next_st.sel_b = pwdata & SEL_WMASK;
        end
        if (wr && idx == REG_CFG) begin
            next_st.cfg = pwdata[CFG_W-1:0];
        end
        // answer one cycle into the access phase
        next_st.pready  = acc & ~st.pready;
        next_st.pslverr = acc & ~st.pready & (idx == REG_NONE);
        next_st.prdata  = (acc & ~st.pready & ~pwrite) ? rdata
                                                        : 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st          <= '0;
            st.sel_a    <= SEL_RST;
            st.sel_b    <= SEL_RST;
            st.cfg      <= CFG_RST;
            st.cnt      <= {NCNT{CW'(CNT_RST)}};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign pready  = st.pready;
    assign prdata  = st.prdata;
    assign pslverr = st.pslverr;

    // *****************************************
    // checks
    // *****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wait;
        ce && psel && penable && !pready;
    endsequence
    sequence s_level_inc0;
        ce && st.cfg[CFG_EN] && !st.cfg[CFG_EDGE] && hit_a &&
        !(wr && idx == REG_CNT0);
    endsequence

    chk_apb_answer: assert property (s_wait |=> pready && !$past(pready))
        else $error("apb answer late");
    chk_count_one: assert property (
        s_level_inc0 |=> st.cnt[0] == $past(st.cnt[0]) + CW'(1))
        else $error("counter 0 missed an increment");
    chk_field_code: assert property (
        hit_a |-> st.sel_a[EVSEL_MSB:EVSEL_LSB] == EVSEL_CODE &&
                  st.sel_a[MASK_LSB +: CAT_N] != '0)
        else $error("hit without valid selection");
    chk_ready_drv: assert property (
        st.sel_a[EVSEL_MSB:EVSEL_LSB] == EVSEL_CODE &&
        st.sel_a[MASK_LSB+CAT_RDY_DRV] && st.sync2[PIN_RDY] &&
        st.sync2[PIN_DRV] |-> hit_a)
        else $error("driven data ready not counted");
    chk_ready_own: assert property (
        st.sel_a[EVSEL_MSB:EVSEL_LSB] == EVSEL_CODE &&
        st.sel_a[MASK_LSB+CAT_RDY_OWN] && st.sync2[PIN_RDY] &&
        st.sync2[PIN_SMP] |-> hit_a)
        else $error("sampled data ready not counted");
    chk_ready_oth: assert property (
        st.sel_a[MASK_LSB +: CAT_N] == 6'h04 && hit_a |->
        st.sync2[PIN_RDY] && !st.sync2[PIN_SMP])
        else $error("unsampled data ready miscounted");
    chk_busy_drv: assert property (
        st.sel_a[MASK_LSB +: CAT_N] == 6'h08 && hit_a |->
        st.sync2[PIN_BSY] && st.sync2[PIN_DRV])
        else $error("driven busy miscounted");
    chk_busy_own: assert property (
        st.sel_b[MASK_LSB +: CAT_N] == 6'h10 && hit_b |->
        st.sync2[PIN_BSY] && st.sync2[PIN_SMP])
        else $error("sampled busy miscounted");
    chk_busy_oth: assert property (
        st.sel_b[MASK_LSB +: CAT_N] == 6'h20 && hit_b |->
        st.sync2[PIN_BSY] && !st.sync2[PIN_SMP])
        else $error("unsampled busy miscounted");
    chk_b_routes: assert property (
        ce && st.cfg[2*CFG_STRIDE+CFG_EN] &&
        !st.cfg[2*CFG_STRIDE+CFG_EDGE] && hit_b &&
        !(wr && idx == REG_CNT0 + 3'h2)
        |=> st.cnt[2] == $past(st.cnt[2]) + CW'(1))
        else $error("counter 2 ignores register b");
    chk_edge_once: assert property (
        ce && st.cfg[CFG_STRIDE+CFG_EN] && st.cfg[CFG_STRIDE+CFG_EDGE] &&
        hit_a && st.prev_hit[0] && !(wr && idx == REG_CNT0 + 3'h1)
        |=> $stable(st.cnt[1]))
        else $error("edge mode counted twice");
    chk_mask_zero: assert property (
        st.sel_a[MASK_LSB +: CAT_N] == '0 |-> !hit_a)
        else $error("hit with empty mask");
endmodule // bdaef_filter
`default_nettype wire

// ===== shared/bdaef_pkg.sv
// constants for the bus data activity event filter
// assumes an APB master and asynchronous bus indications
`default_nettype none
package bdaef_pkg;
    // *****************************************
    // register map
    // *****************************************
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] SEL_A_OFS  = 8'h00;
    localparam logic [7:0] SEL_B_OFS  = 8'h04;
    localparam logic [7:0] CFG_OFS    = 8'h08;
    localparam logic [7:0] CNT0_OFS   = 8'h10;
    localparam logic [7:0] CNT_STRIDE = 8'h04;
    localparam int         NCNT       = 4;
    localparam int         NCNT_A     = 2;
    // *****************************************
    // selection register fields
    // *****************************************
    localparam int          EVSEL_LSB  = 25;
    localparam int          EVSEL_MSB  = 31;
    localparam int          MASK_LSB   = 9;
    localparam int          MASK_MSB   = 24;
    localparam logic [6:0]  EVSEL_CODE = 7'h17;
    localparam logic [31:0] SEL_WMASK  = 32'hffff_fe00;
    localparam logic [31:0] SEL_RST    = 32'h0000_0000;
    // *****************************************
    // activity categories, mask bit positions
    // *****************************************
    localparam int CAT_N       = 6;
    localparam int CAT_RDY_DRV = 0;
    localparam int CAT_RDY_OWN = 1;
    localparam int CAT_RDY_OTH = 2;
    localparam int CAT_BSY_DRV = 3;
    localparam int CAT_BSY_OWN = 4;
    localparam int CAT_BSY_OTH = 5;
    // *****************************************
    // counter configuration fields
    // *****************************************
    localparam int         CFG_W      = 8;
    localparam int         CFG_EN     = 0;
    localparam int         CFG_EDGE   = 1;
    localparam int         CFG_STRIDE = 2;
    localparam logic [7:0] CFG_RST    = 8'h00;
    localparam logic [31:0] CNT_RST   = 32'h0000_0000;
    // *****************************************
    // pin indices in the synchroniser
    // *****************************************
    localparam int PIN_N   = 4;
    localparam int PIN_RDY = 0;
    localparam int PIN_BSY = 1;
    localparam int PIN_DRV = 2;
    localparam int PIN_SMP = 3;
    // *****************************************
    // decoded register index
    // *****************************************
    localparam logic [2:0] REG_SEL_A = 3'h0;
    localparam logic [2:0] REG_SEL_B = 3'h1;
    localparam logic [2:0] REG_CFG   = 3'h2;
    localparam logic [2:0] REG_CNT0  = 3'h3;
    localparam logic [2:0] REG_NONE  = 3'h7;
endpackage
`default_nettype wire

// ===== testbench/bdaef_bus_agent.sv
// model of the other bus agents driving the data phase pins
// assumes phase() is called just after a rising pclk edge
`timescale 1ns/10ps
`default_nettype none
module bdaef_bus_agent (
    input  wire logic pclk,
    output var  logic rdy,
    output var  logic bsy,
    output var  logic drv,
    output var  logic smp
);
    // ************************************
    // one data phase, then idle
    // ************************************
    initial begin
        rdy = 1'b0;
        bsy = 1'b0;
        drv = 1'b0;
        smp = 1'b0;
    end
    task automatic phase(input int b, input int d, input int s, input int n);
        @(posedge pclk);
        rdy <= (b == 0);
        bsy <= (b != 0);
        drv <= (d != 0);
        smp <= (s != 0);
        repeat (n) @(posedge pclk);
        rdy <= 1'b0;
        bsy <= 1'b0;
        // stale qualifiers flip so they never look held
        drv <= (d == 0);
        smp <= (s == 0);
    endtask
endmodule // bdaef_bus_agent
`default_nettype wire

// ===== testbench/bus_data_activity_event_filter_bench.sv
// self-checking bench for the bus data activity event filter
// assumes bdaef_pkg and bdaef_bus_agent are compiled first
`timescale 1ns/10ps
`default_nettype none
module bus_data_activity_event_filter_bench;
    import bdaef_pkg::*;
    // ************************************
    // signals and instances
    // ************************************
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        ce      = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, rdy, bsy, drv, smp;
    int          err_count = 0;
    int          n_tests   = 0;
    int          ex[NCNT];
    always #5 pclk = ~pclk;
    bdaef_filter #(.CW(32)) dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .data_ready_strobe(rdy),
        .data_bus_reserved(bsy), .data_self_driven(drv),
        .data_self_sampled(smp)
    );
    bdaef_bus_agent agent (
        .pclk(pclk), .rdy(rdy), .bsy(bsy), .drv(drv), .smp(smp)
    );
    // ************************************
    // tasks and model
    // ************************************
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] exp, input logic eexp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(nm, q, exp);
        chk("pslverr", {31'h0, e}, {31'h0, eexp});
    endtask
    function automatic int hit(int m, int b, int d, int s);
        return (m & 1 && !b && d) || (m & 2 && !b && s)
            || (m & 4 && !b && !s) || (m & 8 && b && d)
            || (m & 16 && b && s) || (m & 32 && b && !s);
    endfunction
    function automatic int legal(int m);
        // sampled and unsampled never both
        if ((m & 6) == 6) m -= 4;
        if ((m & 48) == 48) m -= 32;
        return m;
    endfunction
    task automatic close_out();
        $display("compares %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ************************************
    // main sequence and watchdog
    // ************************************
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        close_out();
    end
    initial begin
        int          r, i, ma, mb, b, d, s, n;
        logic [31:0] va;
        void'($urandom(93495));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd("sel_a", SEL_A_OFS, SEL_RST, 1'b0);
        rd("sel_b", SEL_B_OFS, SEL_RST, 1'b0);
        rd("cfg", CFG_OFS, 32'(CFG_RST), 1'b0);
        for (i = 0; i < NCNT; i++)
            rd("cnt", CNT0_OFS + CNT_STRIDE * 8'(i), CNT_RST, 1'b0);
        rd("hole", 8'h0c, 32'h0000_0000, 1'b1);
        // level on 0 and 2, edge on 1 and 3
        wr(CFG_OFS, 32'h0000_00dd);
        rd("cfg", CFG_OFS, 32'h0000_00dd, 1'b0);
        $display("register test done");
        for (r = 0; r < 12; r++) begin
            ma = legal(r < 6 ? 1 << r : $urandom % 64);
            mb = legal(r == 6 ? 0 : r < 2 ? 32 >> r : $urandom % 64);
            va = {EVSEL_CODE, 10'h000, 6'(ma), 9'($urandom)};
            wr(SEL_A_OFS, va);
            rd("sel_a", SEL_A_OFS, va & SEL_WMASK, 1'b0);
            wr(SEL_B_OFS, {r == 7 ? 7'h16 : EVSEL_CODE, 10'h000,
                           6'(mb), 9'h1ff});
            for (i = 0; i < NCNT; i++) begin
                wr(CNT0_OFS + CNT_STRIDE * 8'(i), 32'h0000_0000);
                ex[i] = 0;
            end
            repeat (8) begin
                b = $urandom % 2;
                d = $urandom % 2;
                s = $urandom % 2;
                n = ($urandom % 2) ? 4 : 2;
                agent.phase(b, d, s, n);
                ex[0] += n * hit(ma, b, d, s);
                ex[1] += hit(ma, b, d, s);
                if (r != 7) begin
                    ex[2] += n * hit(mb, b, d, s);
                    ex[3] += hit(mb, b, d, s);
                end
            end
            repeat (6) @(posedge pclk);
            if (r == 5) begin
                // frozen: no counts while ce low
                ce <= 1'b0;
                agent.phase(1, 0, 0, 4);
                repeat (2) @(posedge pclk);
                ce <= 1'b1;
                repeat (2) @(posedge pclk);
            end
            for (i = 0; i < NCNT; i++)
                rd("cnt", CNT0_OFS + CNT_STRIDE * 8'(i), 32'(ex[i]),
                   1'b0);
            $display("round %0d done", r);
        end
        close_out();
    end
endmodule // bus_data_activity_event_filter_bench
`default_nettype wire
